// ==== core/usb_bdt_pkg.sv ====
package usb_bdt_pkg;

   localparam int NUM_EP      = 8;
   localparam int EP_IDX_W    = 3;
   localparam int CPU_ADDR_W  = 10;
   localparam int PE_ADDR_W   = 9;
   localparam int DATA_W      = 16;

   // Entry selectors within one endpoint slot (halfword index in local space)
   localparam logic [1:0] ENTRY_TX_ADDR = 2'h0;
   localparam logic [1:0] ENTRY_TX_CNT  = 2'h1;
   localparam logic [1:0] ENTRY_RX_ADDR = 2'h2;
   localparam logic [1:0] ENTRY_RX_CNT  = 2'h3;

   // Processor-side byte offsets within an endpoint slot (stride 16)
   localparam logic [3:0] CPU_OFF_TX_ADDR = 4'h0;
   localparam logic [3:0] CPU_OFF_TX_CNT  = 4'h4;
   localparam logic [3:0] CPU_OFF_RX_ADDR = 4'h8;
   localparam logic [3:0] CPU_OFF_RX_CNT  = 4'hC;
   // Packet-engine local offsets within a slot (stride 8)
   localparam logic [2:0] PE_OFF_TX_ADDR = 3'h0;
   localparam logic [2:0] PE_OFF_TX_CNT  = 3'h2;
   localparam logic [2:0] PE_OFF_RX_ADDR = 3'h4;
   localparam logic [2:0] PE_OFF_RX_CNT  = 3'h6;

   // Field layout
   localparam int CNT_LSB         = 0;
   localparam int CNT_W           = 10;
   localparam int BLOCK_COUNT_LSB = 10;
   localparam int BLOCK_COUNT_W   = 5;
   localparam int BLOCK_SIZE_BIT  = 15;
   localparam int BUF1_LSB        = 16;

   localparam logic [15:0] CNT_MASK     = 16'h03FF;
   localparam logic [15:0] ADDR_MASK    = 16'hFFFE;
   localparam logic [15:0] RXCFG_MASK   = 16'hFC00;
   localparam logic [15:0] RESET_VALUE  = 16'h0000;

   // Capacity figures: block sizes in bytes, largest large-block count
   localparam logic [9:0] SMALL_BLOCK_BYTES = 10'h002;
   localparam logic [9:0] LARGE_BLOCK_BYTES = 10'h020;
   localparam logic [4:0] LARGE_MAX_BLOCKS  = 5'h0F;

   typedef struct packed {
      logic [15:0] txAddr;
      logic [15:0] txCnt;
      logic [15:0] rxAddr;
      logic [15:0] rxCnt;
   } ep_entry_s;

   typedef struct packed {
      logic                  valid;
      logic                  write;
      logic [CPU_ADDR_W-1:0] addr;
      logic [31:0]           wdata;
   } cpu_req_s;

   typedef struct packed {
      logic                 valid;
      logic                 write;
      logic [PE_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]    wdata;
   } pe_req_s;

   typedef struct packed {
      logic                rxDone;
      logic [EP_IDX_W-1:0] ep;
      logic                buf1;
      logic [9:0]          count;
   } rx_report_s;

   typedef struct packed {
      logic [9:0] bytes;
      logic       legal;
   } capacity_s;

endpackage : usb_bdt_pkg

// ==== core/usb_packet_buffer_descriptors.sv ====
`timescale 1ns/1ps
// Functional notes
// - TX count low ten bits, rest reserved
// - Double-buffer TX: second count at 25:16
// - RX address bits 15:1, bit 0 reserved
// - Device writes received count; software reads only
// - Block count 14:10, block size bit 15
// - Small blocks: 2 bytes times count, nonzero
// - Large blocks: 32 times count+1, max 01111
// - Double-buffer RX: buffer 1 fields upper half
// - TX count at n*16+4 / n*8+2
// - RX address at n*16+8 / n*8+4
// - RX count at n*16+12 / n*8+6
// - TX address bits 15:1 first entry
module usb_packet_buffer_descriptors (
   // Clock and reset
   input  wire logic                              clock,
   input  wire logic                              rst,
   // Processor side, descriptor_table_base relative
   input  wire usb_bdt_pkg::cpu_req_s             cpuReq,
   output logic      [31:0]                       cpuRdata,
   output logic                                   cpuRvalid,
   // Packet engine side, local addressing
   input  wire usb_bdt_pkg::pe_req_s              peReq,
   output logic      [15:0]                       peRdata,
   output logic                                   peRvalid,
   // Received-count report from the engine
   input  wire usb_bdt_pkg::rx_report_s           rxReport,
   // Selected endpoint view for the engine
   input  wire logic [usb_bdt_pkg::EP_IDX_W-1:0]  viewEp,
   input  wire logic                              viewBuf1,
   output logic      [9:0]                        viewTxCount,
   output logic      [9:0]                        viewRxCapacity,
   output logic                                   viewRxCapLegal
);

   typedef struct packed {
      usb_bdt_pkg::ep_entry_s [usb_bdt_pkg::NUM_EP-1:0] lo;
      usb_bdt_pkg::ep_entry_s [usb_bdt_pkg::NUM_EP-1:0] hi;
      logic [31:0] cpuRdata;
      logic        cpuRvalid;
      logic [15:0] peRdata;
      logic        peRvalid;
      logic [9:0]  viewTx;
      logic [9:0]  viewCap;
      logic        viewLegal;
   } state_s;

   state_s state_q;
   state_s state_d;

   // Capacity of one receive buffer from its size-select and block count
   function automatic usb_bdt_pkg::capacity_s rx_capacity(input logic sel, input logic [4:0] blocks);
      usb_bdt_pkg::capacity_s c;
      c = '0;
      if (!sel) begin
         c.bytes = 10'(blocks) * usb_bdt_pkg::SMALL_BLOCK_BYTES;
         c.legal = (blocks != 5'h00);
      end else begin
         c.bytes = 10'(10'(blocks) + 10'h001) * usb_bdt_pkg::LARGE_BLOCK_BYTES;
         c.legal = (blocks <= usb_bdt_pkg::LARGE_MAX_BLOCKS);
      end
      return c;
   endfunction : rx_capacity

   // Software-writable bits per entry; the received count is never written by software
   function automatic logic [15:0] write_mask(input logic [1:0] entry);
      case (entry)
         usb_bdt_pkg::ENTRY_TX_ADDR: write_mask = usb_bdt_pkg::ADDR_MASK;
         usb_bdt_pkg::ENTRY_TX_CNT:  write_mask = usb_bdt_pkg::CNT_MASK;
         usb_bdt_pkg::ENTRY_RX_ADDR: write_mask = usb_bdt_pkg::ADDR_MASK;
         usb_bdt_pkg::ENTRY_RX_CNT:  write_mask = usb_bdt_pkg::RXCFG_MASK;
         default:                    write_mask = 16'h0000;
      endcase
   endfunction : write_mask

   function automatic logic [15:0] entry_get(input usb_bdt_pkg::ep_entry_s e, input logic [1:0] entry);
      case (entry)
         usb_bdt_pkg::ENTRY_TX_ADDR: entry_get = e.txAddr;
         usb_bdt_pkg::ENTRY_TX_CNT:  entry_get = e.txCnt;
         usb_bdt_pkg::ENTRY_RX_ADDR: entry_get = e.rxAddr;
         usb_bdt_pkg::ENTRY_RX_CNT:  entry_get = e.rxCnt;
         default:                    entry_get = 16'h0000;
      endcase
   endfunction : entry_get

   function automatic usb_bdt_pkg::ep_entry_s entry_put(input usb_bdt_pkg::ep_entry_s e,
                                                         input logic [1:0] entry,
                                                         input logic [15:0] val);
      usb_bdt_pkg::ep_entry_s r;
      r = e;
      case (entry)
         usb_bdt_pkg::ENTRY_TX_ADDR: r.txAddr = val;
         usb_bdt_pkg::ENTRY_TX_CNT:  r.txCnt  = val;
         usb_bdt_pkg::ENTRY_RX_ADDR: r.rxAddr = val;
         usb_bdt_pkg::ENTRY_RX_CNT:  r.rxCnt  = val;
         default:                    r = e;
      endcase
      return r;
   endfunction : entry_put

   // Processor decode: byte address = ep*16 + entry*4; upper halfword reaches buffer 1 fields
   logic [usb_bdt_pkg::EP_IDX_W-1:0] cpuEp;
   logic [1:0]                       cpuEntry;
   logic                             cpuAligned;
   // Engine decode: local address = ep*8 + entry*2, halfword aligned
   logic [usb_bdt_pkg::EP_IDX_W-1:0] peEp;
   logic [1:0]                       peEntry;
   logic                             peAligned;

   assign cpuEp      = cpuReq.addr[6:4];
   assign cpuEntry   = cpuReq.addr[3:2];
   assign cpuAligned = (cpuReq.addr[1:0] == 2'h0) && (cpuReq.addr[9:7] == 3'h0);
   assign peEp       = peReq.addr[5:3];
   assign peEntry    = peReq.addr[2:1];
   assign peAligned  = (peReq.addr[0] == 1'b0) && (peReq.addr[8:6] == 3'h0);

   always_comb begin
      logic [15:0]            mask;
      logic [15:0]            cur;
      usb_bdt_pkg::capacity_s cap;
      logic [15:0]            cntWord;
      logic [15:0]            cfgWord;
      mask    = '0;
      cur     = '0;
      cap     = '0;
      cntWord = '0;
      cfgWord = '0;
      state_d = state_q;
      state_d.cpuRvalid = 1'b0;
      state_d.peRvalid  = 1'b0;

      // Processor access; unmapped or misaligned reads return zero
      if (cpuReq.valid) begin
         state_d.cpuRvalid = !cpuReq.write;
         state_d.cpuRdata  = 32'h0000_0000;
         if (cpuAligned) begin
            mask = write_mask(cpuEntry);
            if (cpuReq.write) begin
               cur = entry_get(state_q.lo[cpuEp], cpuEntry);
               state_d.lo[cpuEp] = entry_put(state_q.lo[cpuEp], cpuEntry,
                                             (cur & ~mask) | (cpuReq.wdata[15:0] & mask));
               // Upper halfword only exists for the two count entries
               if (cpuEntry == usb_bdt_pkg::ENTRY_TX_CNT || cpuEntry == usb_bdt_pkg::ENTRY_RX_CNT) begin
                  cur = entry_get(state_q.hi[cpuEp], cpuEntry);
                  state_d.hi[cpuEp] = entry_put(state_q.hi[cpuEp], cpuEntry,
                                                (cur & ~mask) | (cpuReq.wdata[31:16] & mask));
               end
            end else begin
               state_d.cpuRdata[15:0] = entry_get(state_q.lo[cpuEp], cpuEntry);
               if (cpuEntry == usb_bdt_pkg::ENTRY_TX_CNT || cpuEntry == usb_bdt_pkg::ENTRY_RX_CNT) begin
                  state_d.cpuRdata[31:16] = entry_get(state_q.hi[cpuEp], cpuEntry);
               end
            end
         end
      end

      // Engine access sees the low halfword; it may write any bit it owns
      if (peReq.valid) begin
         state_d.peRvalid = !peReq.write;
         state_d.peRdata  = 16'h0000;
         if (peAligned) begin
            if (peReq.write) begin
               state_d.lo[peEp] = entry_put(state_d.lo[peEp], peEntry, peReq.wdata);
            end else begin
               state_d.peRdata = entry_get(state_q.lo[peEp], peEntry);
            end
         end
      end

      // Received count of the last accepted OUT/SETUP; last so it wins over a same-cycle write
      if (rxReport.rxDone) begin
         if (rxReport.buf1) begin
            state_d.hi[rxReport.ep].rxCnt[9:0] = rxReport.count;
         end else begin
            state_d.lo[rxReport.ep].rxCnt[9:0] = rxReport.count;
         end
      end

      // Engine view of the selected endpoint buffer
      cntWord = viewBuf1 ? state_q.hi[viewEp].txCnt : state_q.lo[viewEp].txCnt;
      cfgWord = viewBuf1 ? state_q.hi[viewEp].rxCnt : state_q.lo[viewEp].rxCnt;
      cap = rx_capacity(cfgWord[usb_bdt_pkg::BLOCK_SIZE_BIT],
                        cfgWord[usb_bdt_pkg::BLOCK_COUNT_LSB +: usb_bdt_pkg::BLOCK_COUNT_W]);
      state_d.viewTx    = cntWord[usb_bdt_pkg::CNT_LSB +: usb_bdt_pkg::CNT_W];
      state_d.viewCap   = cap.bytes;
      state_d.viewLegal = cap.legal;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         for (int i = 0; i < usb_bdt_pkg::NUM_EP; i++) begin
            state_q.lo[i] <= '{usb_bdt_pkg::RESET_VALUE, usb_bdt_pkg::RESET_VALUE,
                               usb_bdt_pkg::RESET_VALUE, usb_bdt_pkg::RESET_VALUE};
            state_q.hi[i] <= '{usb_bdt_pkg::RESET_VALUE, usb_bdt_pkg::RESET_VALUE,
                               usb_bdt_pkg::RESET_VALUE, usb_bdt_pkg::RESET_VALUE};
         end
         state_q.cpuRdata  <= '0;
         state_q.cpuRvalid <= 1'b0;
         state_q.peRdata   <= '0;
         state_q.peRvalid  <= 1'b0;
         state_q.viewTx    <= '0;
         state_q.viewCap   <= '0;
         state_q.viewLegal <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign cpuRdata       = state_q.cpuRdata;
   assign cpuRvalid      = state_q.cpuRvalid;
   assign peRdata        = state_q.peRdata;
   assign peRvalid       = state_q.peRvalid;
   assign viewTxCount    = state_q.viewTx;
   assign viewRxCapacity = state_q.viewCap;
   assign viewRxCapLegal = state_q.viewLegal;

endmodule : usb_packet_buffer_descriptors

// ==== dv/usb_packet_buffer_descriptors_asserts.sv ====
`timescale 1ns/1ps
module usb_packet_buffer_descriptors_asserts (
   // Clock and reset
   input wire logic                    clock,
   input wire logic                    rst,
   // Watched ports
   input wire usb_bdt_pkg::cpu_req_s   cpuReq,
   input wire logic [31:0]             cpuRdata,
   input wire logic                    cpuRvalid,
   input wire usb_bdt_pkg::pe_req_s    peReq,
   input wire logic [15:0]             peRdata,
   input wire logic                    peRvalid,
   input wire usb_bdt_pkg::rx_report_s rxReport
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_cpu_rd; cpuReq.valid && !cpuReq.write; endsequence
   sequence s_pe_rd; peReq.valid && !peReq.write; endsequence
   // Report, then an undisturbed processor read of the same count entry
   sequence s_rx_read;
      rxReport.rxDone && !rxReport.buf1 ##1
      (cpuReq.valid && !cpuReq.write && !peReq.valid && cpuReq.addr == {3'h0, $past(rxReport.ep), 4'hC});
   endsequence
   property p_cpu_ans; s_cpu_rd |=> cpuRvalid; endproperty
   a_cpu_ans: assert property (p_cpu_ans) else $error("processor read got no answer");
   property p_cpu_quiet; !(cpuReq.valid && !cpuReq.write) |=> !cpuRvalid; endproperty
   a_cpu_quiet: assert property (p_cpu_quiet) else $error("processor answer without a read");
   property p_pe_ans; s_pe_rd |=> peRvalid; endproperty
   a_pe_ans: assert property (p_pe_ans) else $error("engine read got no answer");
   property p_pe_quiet; !(peReq.valid && !peReq.write) |=> !peRvalid; endproperty
   a_pe_quiet: assert property (p_pe_quiet) else $error("engine answer without a read");
   property p_txcnt_rsv; cpuRvalid && $past(cpuReq.addr[3:0]) == 4'h4 |-> (cpuRdata & 32'hFC00FC00) == 32'h0; endproperty
   a_txcnt_rsv: assert property (p_txcnt_rsv) else $error("tx count reserved bits set");
   property p_rxaddr_rsv; cpuRvalid && $past(cpuReq.addr[3:0]) == 4'h8 |-> (cpuRdata & 32'hFFFF0001) == 32'h0; endproperty
   a_rxaddr_rsv: assert property (p_rxaddr_rsv) else $error("rx address reserved bits set");
   property p_unmapped; cpuRvalid && $past(cpuReq.addr) >= 10'h080 |-> cpuRdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("read beyond table not zero");
   property p_pe_odd; peRvalid && $past(peReq.addr[0]) |-> peRdata == 16'h0; endproperty
   a_pe_odd: assert property (p_pe_odd) else $error("odd engine read not zero");
   property p_rx_count; s_rx_read |=> cpuRdata[9:0] == $past(rxReport.count, 2); endproperty
   a_rx_count: assert property (p_rx_count) else $error("received count not stored");
endmodule : usb_packet_buffer_descriptors_asserts

bind usb_packet_buffer_descriptors usb_packet_buffer_descriptors_asserts u_asserts (
   .clock(clock), .rst(rst), .cpuReq(cpuReq), .cpuRdata(cpuRdata), .cpuRvalid(cpuRvalid),
   .peReq(peReq), .peRdata(peRdata), .peRvalid(peRvalid), .rxReport(rxReport));

// ==== dv/usb_host_model.sv ====
`timescale 1ns/1ps
module usb_host_model (
   // Clock
   input  wire logic               clock,
   // Accepted OUT packet reports
   output usb_bdt_pkg::rx_report_s rxReport
);
   initial rxReport = '0;
   // Idle fields are inverted so a stale count is never mistaken for a fresh one
   task automatic send(input logic [2:0] ep, input logic buf1, input logic [9:0] count);
      rxReport = '{1'b1, ep, buf1, count};
      @(negedge clock);
      rxReport = '{1'b0, ~ep, ~buf1, ~count};
   endtask : send
endmodule : usb_host_model

// ==== dv/usb_packet_buffer_descriptors_bench.sv ====
`timescale 1ns/1ps
module usb_packet_buffer_descriptors_bench;
   logic                    clock    = 1'b0;
   logic                    rst      = 1'b1;
   usb_bdt_pkg::cpu_req_s   cpuReq   = '0;
   usb_bdt_pkg::pe_req_s    peReq    = '0;
   usb_bdt_pkg::rx_report_s rxReport;
   logic [2:0]              viewEp   = 3'h1;
   logic                    viewBuf1 = 1'b0;
   logic [31:0]             cpuRdata, rd;
   logic [15:0]             peRdata, prd;
   logic                    cpuRvalid, peRvalid, viewRxCapLegal;
   logic [9:0]              viewTxCount, viewRxCapacity;
   int                      err_total = 0;
   int                      checks = 0;
   typedef struct packed {logic [9:0] wa; logic [31:0] wd; logic [9:0] ra; logic [31:0] exp;} row_s;
   row_s rows [7] = '{
      '{10'h004, 32'hFFFFFFFF, 10'h004, 32'h03FF03FF},
      '{10'h078, 32'hFFFFFFFF, 10'h078, 32'h0000FFFE},
      '{10'h07C, 32'hFFFFFFFF, 10'h07C, 32'hFC00FC00},
      '{10'h070, 32'h1234ABCD, 10'h070, 32'h0000ABCC},
      '{10'h074, 32'h00000155, 10'h074, 32'h00000155},
      '{10'h080, 32'hFFFFFFFF, 10'h080, 32'h00000000},
      '{10'h015, 32'hFFFFFFFF, 10'h014, 32'h00000000}};
   // Receive config word and expected {legal, capacity}; capacity is zero where illegal
   logic [15:0] cfg [6] = '{16'h0C00, 16'h7C00, 16'h0000, 16'h8000, 16'hBC00, 16'hC000};
   // The 512-byte setting fits the ten-bit capacity as 10'h200
   logic [10:0] cap [6] = '{11'h406, 11'h43E, 11'h000, 11'h420, 11'h600, 11'h000};

   always #12.5 clock = ~clock;

   usb_host_model host (.clock(clock), .rxReport(rxReport));
   usb_packet_buffer_descriptors dut (.clock(clock), .rst(rst), .cpuReq(cpuReq), .cpuRdata(cpuRdata),
      .cpuRvalid(cpuRvalid), .peReq(peReq), .peRdata(peRdata), .peRvalid(peRvalid), .rxReport(rxReport),
      .viewEp(viewEp), .viewBuf1(viewBuf1), .viewTxCount(viewTxCount), .viewRxCapacity(viewRxCapacity),
      .viewRxCapLegal(viewRxCapLegal));

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // Called at a falling edge; on release valid and write drop to zero, address and data are inverted
   task automatic cpu_rw(input logic w, input logic [9:0] a, input logic [31:0] d);
      cpuReq = '{1'b1, w, a, d};
      @(negedge clock);
      if (!w) begin
         chk({31'h0, cpuRvalid}, 32'h1);
         rd = cpuRdata;
      end
      cpuReq = '{1'b0, 1'b0, ~a, ~d};
      @(negedge clock);
   endtask : cpu_rw

   task automatic pe_rw(input logic w, input logic [8:0] a, input logic [15:0] d);
      peReq = '{1'b1, w, a, d};
      @(negedge clock);
      if (!w) begin
         chk({31'h0, peRvalid}, 32'h1);
         prd = peRdata;
      end
      peReq = '{1'b0, 1'b0, ~a, ~d};
      @(negedge clock);
   endtask : pe_rw

   task automatic print_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   initial begin
      #(25ns * 4000);
      err_total++;
      print_verdict();
   end

   initial begin
      repeat (12) @(negedge clock);
      rst = 1'b0;
      cpu_rw(1'b0, 10'h07C, 32'h0);
      chk(rd, 32'h0);
      $display("reset test done");
      foreach (rows[i]) begin
         cpu_rw(1'b1, rows[i].wa, rows[i].wd);
         cpu_rw(1'b0, rows[i].ra, 32'h0);
         chk(rd, rows[i].exp);
      end
      $display("table test done");
      host.send(3'h2, 1'b0, 10'h040);
      cpu_rw(1'b0, 10'h02C, 32'h0);
      chk(rd, 32'h00000040);
      host.send(3'h2, 1'b1, 10'h3FF);
      cpu_rw(1'b0, 10'h02C, 32'h0);
      chk(rd, 32'h03FF0040);
      pe_rw(1'b1, 9'h00E, 16'h8C12);
      cpu_rw(1'b0, 10'h01C, 32'h0);
      chk(rd, 32'h00008C12);
      cpu_rw(1'b1, 10'h014, 32'h2A5);
      pe_rw(1'b0, 9'h00A, 16'h0);
      chk({16'h0, prd}, 32'h2A5);
      pe_rw(1'b0, 9'h003, 16'h0);
      chk({16'h0, prd}, 32'h0);
      $display("engine test done");
      foreach (cfg[i]) begin
         cpu_rw(1'b1, 10'h01C, {cfg[i], cfg[i]});
         for (int b = 0; b < 2; b++) begin
            viewBuf1 = b[0];
            repeat (2) @(negedge clock);
            chk({viewRxCapLegal, viewRxCapacity & {10{cap[i][10]}}}, cap[i]);
            chk(viewTxCount, b ? 32'h0 : 32'h2A5);
         end
      end
      $display("capacity test done");
      // A second reset in mid-run must clear the endpoint 1 TX count entry (10'h014) and the view outputs
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      cpu_rw(1'b0, 10'h014, 32'h0);
      chk(rd, 32'h0);
      chk({viewRxCapLegal, viewRxCapacity}, 32'h0);
      chk(viewTxCount, 32'h0);
      $display("mid-run reset test done");
      print_verdict();
   end
endmodule : usb_packet_buffer_descriptors_bench
